// [hw/rirb_bank.sv]
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// - Any reset clears timer C count; wake-up keeps it.
// - Any reset sets timer C period to all ones; wake-up keeps it.
// - Timer C control clears seven low bits on reset; top bit reads zero.
// - Capture controls clear on reset; capture values have no reset.
// - Serial B baud, receive and transmit data clear on any reset.
// - Serial B transmit status resets to 0x02; bit 3 reads zero.
// - Serial B receive status upper seven clear on reset; bit 0 untouched.
// - Port H upper nibble reads zero after reset; lower nibble untouched.
// - Port F low seven bits read zero after reset, and after wake-up unless a same-cycle write sets the port F digital enable.
// - Wake-up raises the flag bits that match the wake cause.
// - Interrupt wake-up with global enable loads the matching vector.
// - Interrupt wake-up with global enable pushes the PC to stack top.
// - Interrupt wake-up with global enable advances the stack pointer unless it is full.
// - Port A bit 6 works only in pin-freeing oscillator modes.
// - Unimplemented bits, port A bit 6 outside the pin-freeing oscillator modes included, always read zero.
module rirb_bank
	import rirb_pkg::*;
#(
	parameter bit A_BIT6_PRESENT = 1'b1
) (
	// Clock and power-on / brown-out reset
	input wire logic clock,
	input wire logic reset,
	// Other reset classes, one-cycle pulse
	input wire logic soft_reset,
	// Register port
	input wire rirb_bus_s bus,
	output logic [7:0] rdata,
	// Pins and oscillator mode, asynchronous
	input wire logic [71:0] port_pins,
	input wire logic [2:0] osc_mode,
	// Serial B receive word
	input wire rirb_rx_s rx,
	// Sleep wake-up and core state
	input wire rirb_wake_s wake,
	input wire logic low_priority_global_enable,
	input wire logic high_priority_global_enable,
	input wire logic [20:0] pc,
	// Wake-up results
	output logic [7:0] wake_flag_set,
	output logic pc_load,
	output logic [20:0] pc_vector,
	output rirb_stack_s stack_top,
	output logic [4:0] hardware_stack_pointer,
	// Interrupt
	output logic irq
);

	logic [71:0] pins_sync;
	logic [2:0] osc_sync;
	logic [7:0] port_in [9];
	logic [7:0] pmask [9];
	logic [7:0] cls [NCLS];
	logic [7:0] und [NUND];
	logic rxs_b0;
	logic [7:0] rv [NREG];
	logic [7:0] rd_or [NREG+1];
	logic [NREG-1:0] wr_hit;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	logic [ST_W-1:0] next_status;
	logic [ST_W-1:0] st_set;
	wire b6ok;
	wire irq_wake;
	wire high_take;
	wire sp_full;

	rirb_sync #(
		.WIDTH(75)
	) u_sync (
		.clock(clock),
		.din({osc_mode, port_pins}),
		.dout({osc_sync, pins_sync})
	);

	// Bit 6 depends on variant and on the oscillator mode
	assign b6ok = A_BIT6_PRESENT &&
		(osc_sync == OSC_EXT_FREE || osc_sync == OSC_RC_FREE);

	// Input registers sample pins; reset state comes from the masks
	genvar p;
	generate
		for (p = 0; p < 9; p++) begin : g_port
			always_ff @(posedge clock) begin
				port_in[p] <= pins_sync[p*8 +: 8];
			end
			assign rv[p] = port_in[p] & pmask[p];
		end
	endgenerate

	assign pmask[0] = {1'b0, b6ok, cls[C_DIG][DIG_A], 1'b1,
		{4{cls[C_DIG][DIG_A]}}};
	assign pmask[1] = 8'hff;
	assign pmask[2] = 8'hff;
	assign pmask[3] = 8'hff;
	assign pmask[4] = 8'hff;
	assign pmask[5] = {1'b1, {7{cls[C_DIG][DIG_F]}}};
	assign pmask[6] = PORT_G_IMPL;
	assign pmask[7] = {{4{cls[C_DIG][DIG_H]}}, 4'hf};
	assign pmask[8] = 8'hff;

	// Address decode
	genvar n;
	generate
		for (n = 0; n < NREG; n++) begin : g_dec
			assign wr_hit[n] = bus.wr && bus.addr == REG_OFS[n];
			assign rd_or[n+1] = rd_or[n] |
				((bus.addr == REG_OFS[n]) ? rv[n] : 8'h00);
		end
	endgenerate
	assign rd_or[0] = 8'h00;

	// Registers reset by every reset class and held over wake-up, except the port F digital enable
	genvar k;
	generate
		for (k = 0; k < NCLS; k++) begin : g_cls
			logic [7:0] wm;
			logic [7:0] next_val;
			logic [7:0] keep;
			if (k == C_ADIR) begin : g_wm6
				assign wm = b6ok ? CLS_WMASK[k] :
					(CLS_WMASK[k] & ~(8'h01 << PA_B6));
			end else begin : g_wm
				assign wm = CLS_WMASK[k];
			end
			if (k == C_DIG) begin : g_wake
				// Port F reverts to analog on wake-up unless a same-cycle write sets its digital enable
				assign keep = wake.valid ?
					(cls[k] & ~(8'h01 << DIG_F)) : cls[k];
			end else begin : g_hold
				assign keep = cls[k];
			end
			if (k == C_RXD) begin : g_rx
				assign next_val = rx.valid ? rx.data : keep;
			end else begin : g_sw
				assign next_val = wr_hit[CLS0+k] ?
					((keep & ~wm) | (bus.wdata & wm)) : keep;
			end
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					cls[k] <= CLS_RST[k];
				end else if (soft_reset) begin
					cls[k] <= CLS_RST[k];
				end else begin
					cls[k] <= next_val;
				end
			end
			if (k == C_ADIR) begin : g_rdir
				assign rv[CLS0+k] = cls[k] &
					{1'b0, b6ok, 6'h3f};
			end else if (k == C_RXS) begin : g_rrxs
				assign rv[CLS0+k] = {cls[k][7:1], rxs_b0};
			end else begin : g_rplain
				assign rv[CLS0+k] = cls[k];
			end
		end
	endgenerate

	// Capture values, port A latch and receive status bit 0 carry no reset
	genvar u;
	generate
		for (u = 0; u < NUND; u++) begin : g_und
			logic [7:0] wm;
			if (u == U_ALAT) begin : g_wm6
				assign wm = b6ok ? UND_WMASK[u] :
					(UND_WMASK[u] & ~(8'h01 << PA_B6));
				assign rv[UND0+u] = und[u] & {1'b0, b6ok, 6'h3f};
			end else begin : g_wm
				assign wm = UND_WMASK[u];
				assign rv[UND0+u] = und[u];
			end
			always_ff @(posedge clock) begin
				if (wr_hit[UND0+u]) begin
					und[u] <= (und[u] & ~wm) | (bus.wdata & wm);
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (wr_hit[CLS0+C_RXS]) begin
			rxs_b0 <= bus.wdata[0];
		end
	end

	// Wake-up vectoring: a high-priority cause needs its own enable
	assign high_take = wake.high_pri && high_priority_global_enable;
	assign irq_wake = wake.valid && wake.by_irq && !soft_reset &&
		(high_take || (!wake.high_pri && low_priority_global_enable));
	assign sp_full = hardware_stack_pointer == SP_FULL;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wake_flag_set <= 8'h00;
			pc_load <= 1'b0;
			pc_vector <= VEC_HIGH;
		end else begin
			wake_flag_set <= wake.valid ? wake.flags : 8'h00;
			pc_load <= irq_wake;
			if (irq_wake) begin
				pc_vector <= high_take ? VEC_HIGH : VEC_LOW;
			end
		end
	end

	// A full stack keeps its pointer; software sees the overflow flag
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stack_top <= '0;
			hardware_stack_pointer <= SP_RST;
		end else if (soft_reset) begin
			hardware_stack_pointer <= SP_RST;
		end else if (irq_wake) begin
			stack_top <= pc;
			if (!sp_full) begin
				hardware_stack_pointer <= hardware_stack_pointer +
					5'h01;
			end
		end
	end

	// Sticky status: a new event wins over a same-cycle clear
	assign st_set[ST_WAKE] = wake.valid;
	assign st_set[ST_RESET] = soft_reset;
	assign st_set[ST_FULL] = irq_wake && sp_full;
	assign next_status = (status &
		~(wr_hit[R_STAT] ? bus.wdata[ST_W-1:0] : '0)) | st_set;
	assign rv[R_STAT] = {5'h00, status};
	assign rv[R_MASK] = {5'h00, mask};
	assign rv[R_SP] = {3'h0, hardware_stack_pointer};

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			status <= '0;
			mask <= '0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			if (wr_hit[R_MASK]) begin
				mask <= bus.wdata[ST_W-1:0];
			end
			irq <= |(next_status &
				(wr_hit[R_MASK] ? bus.wdata[ST_W-1:0] : mask));
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else begin
			rdata <= bus.rd ? rd_or[NREG] : 8'h00;
		end
	end

	// Checks
	sequence s_soft;
		soft_reset;
	endsequence

	sequence s_irq_wake;
		wake.valid && wake.by_irq && !soft_reset &&
			(high_take || (!wake.high_pri && low_priority_global_enable));
	endsequence

	sequence s_quiet_wake;
		wake.valid && !soft_reset && !bus.wr && !rx.valid;
	endsequence

	tmr_clear_a: assert property (@(posedge clock) disable iff (reset)
		s_soft |=> cls[C_TMR] == 8'h00)
		else $error("timer count not cleared by reset");

	period_set_a: assert property (@(posedge clock) disable iff (reset)
		s_soft |=> cls[C_PER] == 8'hff)
		else $error("timer period not set by reset");

	wake_hold_a: assert property (@(posedge clock) disable iff (reset)
		s_quiet_wake |=> $stable(cls[C_TCON]) && $stable(cls[C_TMR])
			&& rv[CLS0+C_TCON][7] == 1'b0)
		else $error("timer registers disturbed by wake-up");

	capture_ctl_a: assert property (@(posedge clock) disable iff (reset)
		s_soft ##0 !bus.wr |=> cls[C_DCON] == 8'h00 &&
			cls[C_ECON] == 8'h00 && $stable(und[U_DLO]))
		else $error("capture registers wrong after reset");

	serial_clear_a: assert property (@(posedge clock) disable iff (reset)
		s_soft |=> cls[C_BAUD] == 8'h00 && cls[C_RXD] == 8'h00 &&
			cls[C_TXD] == 8'h00)
		else $error("serial data not cleared by reset");

	txs_reset_a: assert property (@(posedge clock) disable iff (reset)
		s_soft |=> rv[CLS0+C_TXS] == 8'h02 ##1 rv[CLS0+C_TXS][3] == 1'b0)
		else $error("transmit status reset value wrong");

	rxs_reset_a: assert property (@(posedge clock) disable iff (reset)
		s_soft ##0 !bus.wr |=> cls[C_RXS][7:1] == 7'h00 && $stable(rxs_b0))
		else $error("receive status reset wrong");

	port_h_a: assert property (@(posedge clock) disable iff (reset)
		s_soft |=> rv[P_H][7:4] == 4'h0)
		else $error("port H upper nibble not zero after reset");

	port_f_a: assert property (@(posedge clock) disable iff (reset)
		wake.valid |=> rv[P_F][6:0] == 7'h00)
		else $error("port F low bits not zero after wake-up");

	wake_flag_a: assert property (@(posedge clock) disable iff (reset)
		wake.valid |=> wake_flag_set == $past(wake.flags))
		else $error("wake flags not raised");

	vector_a: assert property (@(posedge clock) disable iff (reset)
		s_irq_wake |=> pc_load && pc_vector ==
			($past(high_take) ? VEC_HIGH : VEC_LOW) ##1 !pc_load ||
			$past(irq_wake))
		else $error("interrupt vector not loaded");

	push_a: assert property (@(posedge clock) disable iff (reset)
		s_irq_wake |=> stack_top == $past(pc))
		else $error("stack top not loaded with PC");

	sp_step_a: assert property (@(posedge clock) disable iff (reset)
		s_irq_wake ##0 !sp_full |=> hardware_stack_pointer ==
			$past(hardware_stack_pointer) + 5'h01)
		else $error("stack pointer not advanced");

	bit6_gate_a: assert property (@(posedge clock) disable iff (reset)
		!b6ok |-> rv[P_A][6] == 1'b0 && rv[CLS0+C_ADIR][6] == 1'b0 &&
			rv[UND0+U_ALAT][6] == 1'b0)
		else $error("port A bit 6 visible in wrong mode");

	unimpl_a: assert property (@(posedge clock) disable iff (reset)
		bus.rd && bus.addr == REG_OFS[P_G] |=> rdata[7:5] == 3'h0)
		else $error("unimplemented port G bits read non-zero");

endmodule

// [hw/rirb_pkg.sv]
package rirb_pkg;

	// Register table: ports, class-reset, unreset, then service registers
	localparam int NREG = 29;
	localparam int NCLS = 12;
	localparam int NUND = 5;
	localparam int CLS0 = 9;
	localparam int UND0 = 21;
	localparam int R_STAT = 26;
	localparam int R_MASK = 27;
	localparam int R_SP = 28;

	// Port indices
	localparam int P_A = 0;
	localparam int P_F = 5;
	localparam int P_G = 6;
	localparam int P_H = 7;

	// Class-reset register indices
	localparam int C_TMR = 0;
	localparam int C_PER = 1;
	localparam int C_TCON = 2;
	localparam int C_DCON = 3;
	localparam int C_ECON = 4;
	localparam int C_BAUD = 5;
	localparam int C_RXD = 6;
	localparam int C_TXD = 7;
	localparam int C_TXS = 8;
	localparam int C_RXS = 9;
	localparam int C_DIG = 10;
	localparam int C_ADIR = 11;

	// Unreset register indices
	localparam int U_DLO = 0;
	localparam int U_DHI = 1;
	localparam int U_ELO = 2;
	localparam int U_EHI = 3;
	localparam int U_ALAT = 4;

	localparam logic [5:0] REG_OFS [NREG] = '{
		6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
		6'h10, 6'h11, 6'h12, 6'h15, 6'h18, 6'h19, 6'h1a, 6'h1b,
		6'h1c, 6'h1d, 6'h20, 6'h0a,
		6'h13, 6'h14, 6'h16, 6'h17, 6'h09,
		6'h21, 6'h22, 6'h23};

	localparam logic [7:0] CLS_RST [NCLS] = '{
		8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h7f};
	localparam logic [7:0] CLS_WMASK [NCLS] = '{
		8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff,
		8'h00, 8'hff, 8'hf7, 8'hfe, 8'h07, 8'h7f};
	localparam logic [7:0] UND_WMASK [NUND] = '{
		8'hff, 8'hff, 8'hff, 8'hff, 8'h7f};

	// Digital-enable bits of the port control register
	localparam int DIG_A = 0;
	localparam int DIG_F = 1;
	localparam int DIG_H = 2;

	localparam logic [7:0] PORT_G_IMPL = 8'h1f;
	localparam int PA_B6 = 6;

	// Oscillator modes that free the port A bit 6 pin
	localparam logic [2:0] OSC_EXT_FREE = 3'h5;
	localparam logic [2:0] OSC_RC_FREE = 3'h7;

	localparam logic [20:0] VEC_HIGH = 21'h000008;
	localparam logic [20:0] VEC_LOW = 21'h000018;
	localparam logic [4:0] SP_FULL = 5'h1f;
	localparam logic [4:0] SP_RST = 5'h00;

	// Interrupt status bits
	localparam int ST_WAKE = 0;
	localparam int ST_RESET = 1;
	localparam int ST_FULL = 2;
	localparam int ST_W = 3;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} rirb_bus_s;

	typedef struct packed {
		logic valid;
		logic by_irq;
		logic high_pri;
		logic [7:0] flags;
	} rirb_wake_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rirb_rx_s;

	typedef struct packed {
		logic [4:0] upper;
		logic [7:0] high;
		logic [7:0] low;
	} rirb_stack_s;

endpackage

// [hw/rirb_sync.sv]
`timescale 1ns/1ps
module rirb_sync #(
	parameter int WIDTH = 75
) (
	// Clock
	input wire logic clock,
	// Asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage;

	// Pin levels have no reset value worth forcing
	always_ff @(posedge clock) begin
		stage <= din;
		dout <= stage;
	end

endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import rirb_pkg::*;
	logic clock, reset, soft_reset;
	rirb_bus_s bus;
	logic [7:0] rdata, wake_flag_set, v;
	logic [71:0] port_pins;
	logic [2:0] osc_mode;
	rirb_rx_s rx;
	rirb_wake_s wake;
	logic gie_low, gie_high, pc_load, irq;
	logic [20:0] pc, pc_vector;
	rirb_stack_s stack_top;
	logic [4:0] sp;
	int fail_count, checks_done;
	// Class registers: offset, reset value, read-back after writing all ones
	// (receive data ignores writes and holds what the receive path loaded)
	localparam logic [5:0] OFS [9] = '{6'h10, 6'h11, 6'h12, 6'h15, 6'h18,
		6'h19, 6'h1a, 6'h1b, 6'h1c};
	localparam logic [7:0] RST [9] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h02};
	localparam logic [7:0] FULL [9] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff,
		8'hff, 8'ha5, 8'hff, 8'hf7};

	rirb_bank u_dut (.clock(clock), .reset(reset), .soft_reset(soft_reset),
		.bus(bus), .rdata(rdata), .port_pins(port_pins),
		.osc_mode(osc_mode), .rx(rx), .wake(wake),
		.low_priority_global_enable(gie_low),
		.high_priority_global_enable(gie_high), .pc(pc),
		.wake_flag_set(wake_flag_set), .pc_load(pc_load),
		.pc_vector(pc_vector), .stack_top(stack_top),
		.hardware_stack_pointer(sp), .irq(irq));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic check(string name, logic [20:0] seen, logic [20:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(logic [5:0] a, logic [7:0] d);
		@(posedge clock);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		bus <= '0;
	endtask

	task automatic rdc(string n, logic [5:0] a, logic [7:0] e, logic [7:0] m);
		@(posedge clock);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		bus <= '0;
		#1;
		v = rdata & m;
		check(n, {13'h0, v}, {13'h0, e});
	endtask

	// Pulse a one-cycle input, then let the registered answer settle
	task automatic pulse_wake(logic irq_cause, logic hp, logic [7:0] fl);
		@(posedge clock);
		wake <= '{1'b1, irq_cause, hp, fl};
		@(posedge clock);
		wake <= '0;
		#1;
	endtask

	task automatic pulse_soft();
		@(posedge clock);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
	endtask

	task automatic pause(int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#200000;
		fail_count++;
		summarize();
	end

	initial begin
		reset = 1'b1;
		soft_reset = 1'b0;
		bus = '0;
		port_pins = '0;
		osc_mode = 3'h0;
		rx = '0;
		wake = '0;
		gie_low = 1'b0;
		gie_high = 1'b0;
		pc = '0;
		pause(8);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++)
			rdc("reset value", OFS[i], RST[i], 8'hff);
		rdc("unmapped", 6'h3f, 8'h00, 8'hff);
		rdc("rx status", 6'h1d, 8'h00, 8'hfe);
		$display("test reset values done");

		for (int i = 0; i < 9; i++)
			wr(OFS[i], 8'hff);
		wr(6'h1d, 8'hff);
		wr(6'h13, 8'h3c);
		wr(6'h09, 8'hff);
		rx <= '{1'b1, 8'ha5};
		@(posedge clock);
		rx <= '0;
		for (int i = 0; i < 9; i++)
			rdc("written", OFS[i], FULL[i], 8'hff);
		pulse_wake(1'b0, 1'b0, 8'h00);
		for (int i = 0; i < 9; i++)
			rdc("kept on wake", OFS[i], FULL[i], 8'hff);
		rdc("rx status kept", 6'h1d, 8'hfe, 8'hfe);
		pulse_soft();
		for (int i = 0; i < 9; i++)
			rdc("soft reset", OFS[i], RST[i], 8'hff);
		rdc("rx status soft", 6'h1d, 8'h00, 8'hfe);
		rdc("capture kept", 6'h13, 8'h3c, 8'hff);
		rdc("latch gated", 6'h09, 8'h3f, 8'hff);
		$display("test wake and soft reset done");

		port_pins <= '1;
		osc_mode <= OSC_EXT_FREE;
		pause(4);
		rdc("port f", 6'h05, 8'h80, 8'hff);
		rdc("port h", 6'h07, 8'h0f, 8'hff);
		rdc("port a", 6'h00, 8'h50, 8'hff);
		rdc("port g", 6'h06, 8'h1f, 8'hff);
		wr(6'h20, 8'h07);
		rdc("port f on", 6'h05, 8'hff, 8'hff);
		rdc("port a on", 6'h00, 8'h7f, 8'hff);
		rdc("dir free", 6'h0a, 8'h7f, 8'hff);
		osc_mode <= 3'h0;
		pause(4);
		rdc("port a gated", 6'h00, 8'h3f, 8'hff);
		rdc("dir gated", 6'h0a, 8'h3f, 8'hff);
		osc_mode <= OSC_RC_FREE;
		pause(4);
		rdc("port a rc", 6'h00, 8'h7f, 8'hff);
		wr(6'h09, 8'hff);
		rdc("latch rc", 6'h09, 8'h7f, 8'hff);
		pulse_wake(1'b0, 1'b0, 8'h00);
		rdc("port f wake", 6'h05, 8'h80, 8'hff);
		pulse_soft();
		rdc("port h soft", 6'h07, 8'h0f, 8'hff);
		$display("test ports done");

		gie_high <= 1'b1;
		pc <= 21'h1abcde;
		pulse_wake(1'b1, 1'b1, 8'h5a);
		check("wake flags", {13'h0, wake_flag_set}, 21'h00005a);
		check("pc load", {20'h0, pc_load}, 21'h1);
		check("vector high", pc_vector, 21'h000008);
		check("stack top", stack_top, 21'h1abcde);
		check("pointer one", {16'h0, sp}, 21'h1);
		@(posedge clock);
		#1;
		check("pc load ends", {20'h0, pc_load}, 21'h0);
		gie_high <= 1'b0;
		gie_low <= 1'b1;
		pc <= 21'h02468a;
		pulse_wake(1'b1, 1'b0, 8'h81);
		check("wake flags low", {13'h0, wake_flag_set}, 21'h000081);
		check("vector low", pc_vector, 21'h000018);
		check("stack top low", stack_top, 21'h02468a);
		check("pointer two", {16'h0, sp}, 21'h2);
		gie_low <= 1'b0;
		pulse_wake(1'b1, 1'b1, 8'h00);
		check("no load", {20'h0, pc_load}, 21'h0);
		check("pointer kept", {16'h0, sp}, 21'h2);
		rdc("pointer reg", 6'h23, 8'h02, 8'hff);
		$display("test interrupt wake done");

		wr(6'h22, 8'h00);
		pause(2);
		#1;
		check("irq masked", {20'h0, irq}, 21'h0);
		rdc("status", 6'h21, 8'h03, 8'hff);
		wr(6'h22, 8'h01);
		pause(2);
		#1;
		check("irq raised", {20'h0, irq}, 21'h1);
		wr(6'h21, 8'h01);
		pause(2);
		#1;
		check("irq cleared", {20'h0, irq}, 21'h0);
		rdc("status left", 6'h21, 8'h02, 8'hff);
		wr(6'h22, 8'h02);
		pause(2);
		#1;
		check("irq soft", {20'h0, irq}, 21'h1);
		wr(6'h21, 8'h02);
		rdc("status clear", 6'h21, 8'h00, 8'hff);
		gie_high <= 1'b1;
		repeat (30) pulse_wake(1'b1, 1'b1, 8'h00);
		check("pointer full", {16'h0, sp}, 21'h1f);
		rdc("stack full", 6'h21, 8'h05, 8'hff);
		$display("test interrupt done");
		summarize();
	end
endmodule
